// ### logic/monitor_cfg_pkg.sv
// Register map, field layout and carrier types of the monitor configuration bank.
package monitor_cfg_pkg;

    localparam int REG_W = 8;

    // Byte offsets seen by the two-wire interface engine.
    localparam logic [7:0] OFS_CONVERTER_SUPPLY_SELECT = 8'hb5;
    localparam logic [7:0] OFS_TEMPERATURE_SOURCE_CONFIG = 8'hb6;
    localparam logic [7:0] OFS_LOOP_OPERATION_ENABLES = 8'hb7;
    localparam logic [7:0] OFS_LOW_POWER_PIN_RESPONSE = 8'hb8;
    localparam logic [7:0] OFS_THERMAL_TRIM = 8'hb9;
    localparam logic [7:0] OFS_RECEIVE_POWER_SLOPE_THRESHOLD = 8'hba;
    localparam logic [7:0] OFS_PIN_FUNCTION_POLARITY = 8'hbe;
    localparam logic [7:0] OFS_OUTPUT_QUIET_MASK = 8'hbf;
    localparam logic [7:0] OFS_FORCED_FAULT_CONTROL = 8'hc0;

    // Writable bit masks; everything else ignores writes and reads zero.
    localparam logic [7:0] MSK_CONVERTER_SUPPLY_SELECT = 8'h30;
    localparam logic [7:0] MSK_TEMPERATURE_SOURCE_CONFIG = 8'he0;
    localparam logic [7:0] MSK_LOOP_OPERATION_ENABLES = 8'hdd;
    localparam logic [7:0] MSK_LOW_POWER_PIN_RESPONSE = 8'h33;
    localparam logic [7:0] MSK_THERMAL_TRIM = 8'h3f;
    localparam logic [7:0] MSK_RECEIVE_POWER_SLOPE_THRESHOLD = 8'hff;
    localparam logic [7:0] MSK_PIN_FUNCTION_POLARITY = 8'h7f;
    localparam logic [7:0] MSK_OUTPUT_QUIET_MASK = 8'h07;
    localparam logic [7:0] MSK_FORCED_FAULT_CONTROL = 8'h01;

    // Reset values.
    localparam logic [7:0] RST_CONVERTER_SUPPLY_SELECT = 8'h00;
    localparam logic [7:0] RST_TEMPERATURE_SOURCE_CONFIG = 8'h60;
    localparam logic [7:0] RST_LOOP_OPERATION_ENABLES = 8'hdc;
    localparam logic [7:0] RST_LOW_POWER_PIN_RESPONSE = 8'h00;
    localparam logic [7:0] RST_THERMAL_TRIM = 8'h1f;
    localparam logic [7:0] RST_RECEIVE_POWER_SLOPE_THRESHOLD = 8'hff;
    localparam logic [7:0] RST_PIN_FUNCTION_POLARITY = 8'h40;
    localparam logic [7:0] RST_OUTPUT_QUIET_MASK = 8'h03;
    localparam logic [7:0] RST_FORCED_FAULT_CONTROL = 8'h00;

    // Field positions.
    localparam int SUPPLY_SEL_LO = 4;
    localparam int TEMP_EXTERNAL_BIT = 7;
    localparam int THERMAL_KEEP_POWERED_BIT = 5;
    localparam int BIAS_LOAD_EN_BIT = 7;
    localparam int DDM_RECALC_EN_BIT = 6;
    localparam int TRACKING_EN_BIT = 4;
    localparam int APD_LOAD_EN_BIT = 3;
    localparam int MOD_LOAD_EN_BIT = 2;
    localparam int MAIN_LOOP_EN_BIT = 0;
    localparam int RECEIVE_LOWPOWER_FOLLOW_BIT = 4;
    localparam int TRANSMIT_LOWPOWER_FOLLOW_BIT = 0;
    localparam int DAC_SELECT_BIT = 6;
    localparam int SIGNAL_DETECT_SELECT_BIT = 5;
    localparam int FAULT_INVERT_BIT = 4;
    localparam int LOS_POLARITY_BIT = 3;
    localparam int DISABLE_INVERT_BIT = 0;
    localparam int SIGNAL_DETECT_ALLOW_BIT = 2;
    localparam int LOS_INHIBIT_BIT = 1;
    localparam int LASER_INHIBIT_BIT = 0;
    localparam int SOFT_FAULT_BIT = 0;
    localparam int TRIM_W = 6;

    // Register access request from the two-wire interface engine.
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
    } reg_req_t;

    // Levels arriving from the pins and from neighbouring blocks.
    typedef struct packed {
        logic lowpower_pin;
        logic tx_disable_pin;
        logic tx_fault;
        logic tx_signal_detect;
        logic rx_signal_present;
        logic dac_level;
        logic thermal_power_setting;
        logic txfault_soft_en;
        logic shutdown_soft_en;
    } pin_in_t;

endpackage : monitor_cfg_pkg

// ### logic/monitor_loop_pin_config_regs.sv
// Configuration bank for supply, thermal, loop, low-power and pin controls.
// How it works
// - Supply select bits 5:4, reset 00, pick the sampled supply rail.
// - Temperature bit 7, reset 0: 1 external sensor, 0 internal sensor.
// - Keep-powered bit 5 holds sensor on; cleared, power setting decides.
// - Each enabled loop operation except tracking runs exactly once per loop iteration.
// - Loop enable bit 0, reset 0; cleared means no loop operations.
// - Bit 7, reset 1, loads the bias DAC from its table each iteration.
// - Bit 6, reset 1, recalculates monitoring values each iteration.
// - Bit 4, reset 1, makes the power monitor use tracking table values.
// - Bit 3, reset 1, loads photodiode bias DAC from its table each pass.
// - Bit 2, reset 1, loads modulation DAC from its table each iteration.
// - Receive follow bit 4 powers receive down while low-power pin high.
// - Transmit follow bit 0 powers transmit down while low-power pin high.
// - Six-bit read-write thermal trim field at bits 5:0.
// - Receive samples above the threshold, reset ff, use calibration set 1.
// - Pin function bit 6, reset 1: DAC output, else transmit fault.
// - Bit 4, reset 0, inverts the transmit fault before its pin.
// - Bit 3, reset 0: 1 drives loss pin high when signal is present.
// - Bit 0, reset 0, inverts the transmit disable pin input.
// - Signal-detect allow bit 2 cleared forces signal-detect output high.
// - Loss inhibit bit 1, reset 1, forces the loss output high.
// - Laser inhibit bit 0, reset 1, shuts modulated and bias outputs.
// - Forced fault bit 0 asserts the software fault until written back 0.
// - Software fault reaches each safety path only through its enable.
`timescale 1ns/1ps

module monitor_loop_pin_config_regs
    import monitor_cfg_pkg::*;
#(
    parameter int DATA_W = REG_W
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire reg_req_t req_i,
    input wire logic loop_start_i,
    input wire logic [7:0] rx_power_code_i,
    input wire pin_in_t pins_i,
    output logic [7:0] rd_data_o,
    output logic [1:0] supply_sel_o,
    output logic temp_external_o,
    output logic thermal_sensor_power_o,
    output logic [TRIM_W-1:0] thermal_trim_o,
    output logic bias_load_o,
    output logic ddm_recalc_o,
    output logic apd_load_o,
    output logic mod_load_o,
    output logic tracking_table_o,
    output logic rx_powerdown_o,
    output logic tx_powerdown_o,
    output logic rcv_use_upper_o,
    output logic shared_pin_a_o,
    output logic shared_pin_b_o,
    output logic transmit_signal_detect_output_o,
    output logic loss_of_signal_o,
    output logic tx_disable_effective_o,
    output logic tx_out_enable_o,
    output logic bias_out_enable_o,
    output logic soft_fault_to_txfault_o,
    output logic soft_fault_to_shutdown_o
);

    // The byte port and the register map are fixed at eight bits.
    if (DATA_W != REG_W) begin : g_bad_width
        $error("DATA_W must equal the register width");
    end

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] converter_supply_select;
    logic [7:0] temperature_source_config;
    logic [7:0] loop_operation_enables;
    logic [7:0] low_power_pin_response;
    logic [7:0] thermal_trim;
    logic [7:0] receive_power_slope_threshold;
    logic [7:0] pin_function_polarity;
    logic [7:0] output_quiet_mask;
    logic [7:0] forced_fault_control;

    wire logic hit_supply = req_i.addr == OFS_CONVERTER_SUPPLY_SELECT;
    wire logic hit_temp = req_i.addr == OFS_TEMPERATURE_SOURCE_CONFIG;
    wire logic hit_loop = req_i.addr == OFS_LOOP_OPERATION_ENABLES;
    wire logic hit_sleep = req_i.addr == OFS_LOW_POWER_PIN_RESPONSE;
    wire logic hit_trim = req_i.addr == OFS_THERMAL_TRIM;
    wire logic hit_thresh = req_i.addr == OFS_RECEIVE_POWER_SLOPE_THRESHOLD;
    wire logic hit_pinfn = req_i.addr == OFS_PIN_FUNCTION_POLARITY;
    wire logic hit_quiet = req_i.addr == OFS_OUTPUT_QUIET_MASK;
    wire logic hit_fault = req_i.addr == OFS_FORCED_FAULT_CONTROL;

    // Unmapped offsets read as zero so the engine never sees stale data.
    wire logic [7:0] next_rd_data =
        hit_supply ? converter_supply_select :
        hit_temp ? temperature_source_config :
        hit_loop ? loop_operation_enables :
        hit_sleep ? low_power_pin_response :
        hit_trim ? thermal_trim :
        hit_thresh ? receive_power_slope_threshold :
        hit_pinfn ? pin_function_polarity :
        hit_quiet ? output_quiet_mask :
        hit_fault ? forced_fault_control : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // masked register writes
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            converter_supply_select <= RST_CONVERTER_SUPPLY_SELECT;
            temperature_source_config <= RST_TEMPERATURE_SOURCE_CONFIG;
            loop_operation_enables <= RST_LOOP_OPERATION_ENABLES;
            low_power_pin_response <= RST_LOW_POWER_PIN_RESPONSE;
            thermal_trim <= RST_THERMAL_TRIM;
            receive_power_slope_threshold <= RST_RECEIVE_POWER_SLOPE_THRESHOLD;
            pin_function_polarity <= RST_PIN_FUNCTION_POLARITY;
            output_quiet_mask <= RST_OUTPUT_QUIET_MASK;
            forced_fault_control <= RST_FORCED_FAULT_CONTROL;
        end else if (req_i.wr) begin
            if (hit_supply) begin
                converter_supply_select <=
                    req_i.wdata & MSK_CONVERTER_SUPPLY_SELECT;
            end
            if (hit_temp) begin
                temperature_source_config <=
                    req_i.wdata & MSK_TEMPERATURE_SOURCE_CONFIG;
            end
            if (hit_loop) begin
                loop_operation_enables <=
                    req_i.wdata & MSK_LOOP_OPERATION_ENABLES;
            end
            if (hit_sleep) begin
                low_power_pin_response <=
                    req_i.wdata & MSK_LOW_POWER_PIN_RESPONSE;
            end
            if (hit_trim) begin
                thermal_trim <= req_i.wdata & MSK_THERMAL_TRIM;
            end
            if (hit_thresh) begin
                receive_power_slope_threshold <=
                    req_i.wdata & MSK_RECEIVE_POWER_SLOPE_THRESHOLD;
            end
            if (hit_pinfn) begin
                pin_function_polarity <=
                    req_i.wdata & MSK_PIN_FUNCTION_POLARITY;
            end
            if (hit_quiet) begin
                output_quiet_mask <= req_i.wdata & MSK_OUTPUT_QUIET_MASK;
            end
            if (hit_fault) begin
                forced_fault_control <= req_i.wdata & MSK_FORCED_FAULT_CONTROL;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // loop enable gate
    wire logic loop_go = loop_start_i &
        loop_operation_enables[MAIN_LOOP_EN_BIT];

    wire logic next_bias_load =
        loop_go & loop_operation_enables[BIAS_LOAD_EN_BIT];
    wire logic next_ddm_recalc =
        loop_go & loop_operation_enables[DDM_RECALC_EN_BIT];
    wire logic next_apd_load =
        loop_go & loop_operation_enables[APD_LOAD_EN_BIT];
    wire logic next_mod_load =
        loop_go & loop_operation_enables[MOD_LOAD_EN_BIT];
    wire logic next_tracking = loop_operation_enables[MAIN_LOOP_EN_BIT] &
        loop_operation_enables[TRACKING_EN_BIT];

    wire logic next_sensor_power =
        temperature_source_config[THERMAL_KEEP_POWERED_BIT] |
        pins_i.thermal_power_setting;

    wire logic next_rx_pd = pins_i.lowpower_pin &
        low_power_pin_response[RECEIVE_LOWPOWER_FOLLOW_BIT];
    wire logic next_tx_pd = pins_i.lowpower_pin &
        low_power_pin_response[TRANSMIT_LOWPOWER_FOLLOW_BIT];

    wire logic next_use_upper =
        rx_power_code_i > receive_power_slope_threshold;

    wire logic fault_level =
        pins_i.tx_fault ^ pin_function_polarity[FAULT_INVERT_BIT];
    wire logic next_sd_out = ~output_quiet_mask[SIGNAL_DETECT_ALLOW_BIT] |
        pins_i.tx_signal_detect;
    wire logic next_pin_a = pin_function_polarity[DAC_SELECT_BIT] ?
        pins_i.dac_level : fault_level;
    wire logic next_pin_b = pin_function_polarity[SIGNAL_DETECT_SELECT_BIT] ?
        next_sd_out : fault_level;
    wire logic los_level = pin_function_polarity[LOS_POLARITY_BIT] ?
        pins_i.rx_signal_present : ~pins_i.rx_signal_present;
    wire logic next_los = output_quiet_mask[LOS_INHIBIT_BIT] | los_level;
    wire logic next_disable = pins_i.tx_disable_pin ^
        pin_function_polarity[DISABLE_INVERT_BIT];
    wire logic next_laser_on = ~output_quiet_mask[LASER_INHIBIT_BIT];
    wire logic soft_fault = forced_fault_control[SOFT_FAULT_BIT];
    wire logic next_soft_tx = soft_fault & pins_i.txfault_soft_en;
    wire logic next_soft_sd = soft_fault & pins_i.shutdown_soft_en;

    ////////////////////////////////////////////////////////////////////////
    // Every output is a flop, so pins see one cycle of latency after a write.
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            rd_data_o <= 8'h00;
            bias_load_o <= 1'b0;
            ddm_recalc_o <= 1'b0;
            apd_load_o <= 1'b0;
            mod_load_o <= 1'b0;
            tracking_table_o <= 1'b0;
            rx_powerdown_o <= 1'b0;
            tx_powerdown_o <= 1'b0;
            rcv_use_upper_o <= 1'b0;
            shared_pin_a_o <= 1'b0;
            shared_pin_b_o <= 1'b0;
            transmit_signal_detect_output_o <= 1'b1;
            loss_of_signal_o <= 1'b1;
            tx_disable_effective_o <= 1'b0;
            tx_out_enable_o <= 1'b0;
            bias_out_enable_o <= 1'b0;
            soft_fault_to_txfault_o <= 1'b0;
            soft_fault_to_shutdown_o <= 1'b0;
        end else begin
            rd_data_o <= next_rd_data;
            bias_load_o <= next_bias_load;
            ddm_recalc_o <= next_ddm_recalc;
            apd_load_o <= next_apd_load;
            mod_load_o <= next_mod_load;
            tracking_table_o <= next_tracking;
            rx_powerdown_o <= next_rx_pd;
            tx_powerdown_o <= next_tx_pd;
            rcv_use_upper_o <= next_use_upper;
            shared_pin_a_o <= next_pin_a;
            shared_pin_b_o <= next_pin_b;
            transmit_signal_detect_output_o <= next_sd_out;
            loss_of_signal_o <= next_los;
            tx_disable_effective_o <= next_disable;
            tx_out_enable_o <= next_laser_on;
            bias_out_enable_o <= next_laser_on;
            soft_fault_to_txfault_o <= next_soft_tx;
            soft_fault_to_shutdown_o <= next_soft_sd;
        end
    end

    // Static selections come straight from their register bits; sensor power also ORs in the power-setting input.
    // supply select
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            supply_sel_o <= 2'b00;
            temp_external_o <= 1'b0;
            thermal_sensor_power_o <= 1'b1;
            thermal_trim_o <= RST_THERMAL_TRIM[TRIM_W-1:0];
        end else begin
            supply_sel_o <= converter_supply_select[SUPPLY_SEL_LO +: 2];
            temp_external_o <= temperature_source_config[TEMP_EXTERNAL_BIT];
            thermal_sensor_power_o <= next_sensor_power;
            thermal_trim_o <= thermal_trim[TRIM_W-1:0];
        end
    end

endmodule : monitor_loop_pin_config_regs

// ### verification/monitor_cfg_checker.sv
// Port-level assertions for the monitor configuration bank.
`timescale 1ns/1ps
module monitor_cfg_checker
    import monitor_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire reg_req_t req_i,
    input wire logic loop_start_i,
    input wire logic [7:0] rx_power_code_i,
    input wire pin_in_t pins_i,
    input wire logic [7:0] rd_data_o,
    input wire logic [1:0] supply_sel_o,
    input wire logic temp_external_o,
    input wire logic [TRIM_W-1:0] thermal_trim_o,
    input wire logic bias_load_o,
    input wire logic mod_load_o,
    input wire logic rcv_use_upper_o,
    input wire logic rx_powerdown_o,
    input wire logic tx_powerdown_o,
    input wire logic tx_out_enable_o,
    input wire logic bias_out_enable_o,
    input wire logic soft_fault_to_txfault_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // A write is taken at one edge; derived outputs show it two edges on.
    sequence wr_to(logic [7:0] ofs);
        req_i.wr && req_i.addr == ofs;
    endsequence
    ////////////////////////////////////////////////////////////////////////////
    supply_follow_a: assert property (
        wr_to(OFS_CONVERTER_SUPPLY_SELECT) |->
        ##2 supply_sel_o == $past(req_i.wdata[5:4], 2))
        else $error("supply select");
    temp_source_a: assert property (
        wr_to(OFS_TEMPERATURE_SOURCE_CONFIG) |->
        ##2 temp_external_o == $past(req_i.wdata[7], 2))
        else $error("temp source");
    trim_follow_a: assert property (
        wr_to(OFS_THERMAL_TRIM) |->
        ##2 thermal_trim_o == $past(req_i.wdata[5:0], 2))
        else $error("trim field");
    loop_cause_a: assert property ((bias_load_o || mod_load_o) |->
        $past(loop_start_i)) else $error("loop pulse without start");
    unmapped_zero_a: assert property (!($past(req_i.addr) inside
        {[8'hb5:8'hba], [8'hbe:8'hc0]}) |-> rd_data_o == 8'h00)
        else $error("unmapped read");
    supply_undef_a: assert property ($past(req_i.addr) == 8'hb5 |->
        (rd_data_o & 8'hcf) == 8'h00) else $error("undefined bits");
    rcv_upper_a: assert property ($past(rx_power_code_i) == 8'h00 |->
        !rcv_use_upper_o) else $error("upper set on zero sample");
    lowpower_gate_a: assert property (
        (rx_powerdown_o || tx_powerdown_o) |-> $past(pins_i.lowpower_pin))
        else $error("powerdown without pin");
    laser_pair_a: assert property (
        tx_out_enable_o == bias_out_enable_o) else $error("laser outputs split");
    laser_follow_a: assert property (
        wr_to(OFS_OUTPUT_QUIET_MASK) |->
        ##2 tx_out_enable_o == !$past(req_i.wdata[LASER_INHIBIT_BIT], 2))
        else $error("laser inhibit");
    soft_gate_a: assert property (soft_fault_to_txfault_o |->
        $past(pins_i.txfault_soft_en)) else $error("soft fault ungated");
endmodule : monitor_cfg_checker

bind monitor_loop_pin_config_regs monitor_cfg_checker u_chk (
    .clk_i, .sys_rst_i, .req_i, .loop_start_i, .rx_power_code_i, .pins_i,
    .rd_data_o, .supply_sel_o, .temp_external_o, .thermal_trim_o,
    .bias_load_o, .mod_load_o, .rcv_use_upper_o, .rx_powerdown_o,
    .tx_powerdown_o, .tx_out_enable_o, .bias_out_enable_o,
    .soft_fault_to_txfault_o
);

// ### verification/host_model.sv
// Stand-in for the two-wire engine that issues byte requests to the bank.
`timescale 1ns/1ps
module host_model
    import monitor_cfg_pkg::*;
(
    input wire logic clk_i,
    input wire logic [7:0] rd_data_i,
    output reg_req_t req_o
);
    initial req_o = '0;
    // Tasks start on a falling edge, so a strobe spans one rising edge and
    // back-to-back writes stay legal without a gap.
    task write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o = '{addr: a, wdata: d, wr: 1'b1};
    endtask : write_reg
    task idle(input int n);
        repeat (n) begin
            @(negedge clk_i);
            req_o.wr = 1'b0;
        end
    endtask : idle
    task read_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        req_o = '{addr: a, wdata: 8'h00, wr: 1'b0};
        @(negedge clk_i);
        d = rd_data_i;
    endtask : read_reg
endmodule : host_model

// ### verification/tb_top.sv
// Self-checking bench for the monitor configuration bank.
`timescale 1ns/1ps
module tb_top
    import monitor_cfg_pkg::*;
;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic loop_start = 1'b0;
    logic [7:0] rx_code = 8'h00;
    pin_in_t pins = '0;
    reg_req_t req;
    logic [7:0] rd_data, rv;
    logic [1:0] supply_sel;
    logic [5:0] trim;
    logic temp_ext, sens_pwr, bias_ld, ddm_rc, apd_ld, mod_ld, track, rx_pd;
    logic tx_pd, rcv_up, pin_a, pin_b, sd_out, loss, dis_eff, tx_en, bias_en;
    logic sf_tx, sf_sd;
    wire [3:0] pulses = {bias_ld, ddm_rc, apd_ld, mod_ld};
    wire [6:0] pinv = {pin_a, pin_b, sd_out, loss, dis_eff, tx_en, bias_en};
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [7:0] ofs [9] = '{8'hb5, 8'hb6, 8'hb7, 8'hb8, 8'hb9, 8'hba, 8'hbe,
        8'hbf, 8'hc0};
    logic [7:0] rst [9] = '{8'h00, 8'h60, 8'hdc, 8'h00, 8'h1f, 8'hff, 8'h40,
        8'h03, 8'h00};
    logic [7:0] msk [9] = '{8'h30, 8'he0, 8'hdd, 8'h33, 8'h3f, 8'hff, 8'h7f,
        8'h07, 8'h01};
    logic [7:0] lv [4] = '{8'hdd, 8'h8d, 8'h45, 8'hdc};
    logic [7:0] pv [3] = '{8'h00, 8'h69, 8'h10};
    logic [7:0] pe [3] = '{8'h63, 8'h0f, 8'h03};
    logic [3:0] exp_p;

    monitor_loop_pin_config_regs dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .req_i(req), .loop_start_i(loop_start), .rx_power_code_i(rx_code),
        .pins_i(pins), .rd_data_o(rd_data), .supply_sel_o(supply_sel),
        .temp_external_o(temp_ext), .thermal_sensor_power_o(sens_pwr),
        .thermal_trim_o(trim), .bias_load_o(bias_ld), .ddm_recalc_o(ddm_rc),
        .apd_load_o(apd_ld), .mod_load_o(mod_ld), .tracking_table_o(track),
        .rx_powerdown_o(rx_pd), .tx_powerdown_o(tx_pd),
        .rcv_use_upper_o(rcv_up), .shared_pin_a_o(pin_a),
        .shared_pin_b_o(pin_b), .transmit_signal_detect_output_o(sd_out),
        .loss_of_signal_o(loss), .tx_disable_effective_o(dis_eff),
        .tx_out_enable_o(tx_en), .bias_out_enable_o(bias_en),
        .soft_fault_to_txfault_o(sf_tx), .soft_fault_to_shutdown_o(sf_sd));
    host_model host (.clk_i(clk_i), .rd_data_i(rd_data), .req_o(req));

    initial forever #50 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Three idle cycles cover the register edge and the derived-output edge.
    task put(input logic [7:0] a, input logic [7:0] d);
        host.write_reg(a, d);
        host.idle(3);
    endtask : put
    task get(input logic [7:0] a, input logic [7:0] exp);
        host.read_reg(a, rv);
        check(rv, exp);
    endtask : get
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            complete_run();
        end
    end

    initial begin
        repeat (16) @(negedge clk_i);
        sys_rst_i = 1'b0;
        // Reset values, then masks after back-to-back writes.
        for (int i = 0; i < 9; i++) get(ofs[i], rst[i]);
        check(8'({trim, sens_pwr, loss}), 8'h7f);
        check(8'({sd_out, tx_en}), 8'h02);
        for (int i = 0; i < 9; i++) host.write_reg(ofs[i], 8'hff);
        host.write_reg(8'hbb, 8'hff);
        host.write_reg(8'hc1, 8'hff);
        for (int i = 0; i < 9; i++) get(ofs[i], msk[i]);
        get(8'hbb, 8'h00);
        get(8'hc1, 8'h00);
        for (int i = 0; i < 9; i++) put(ofs[i], 8'h00);
        for (int k = 0; k < 4; k++) begin
            put(8'hb5, 8'(k << 4));
            check(8'(supply_sel), 8'(k));
        end
        put(8'hb6, 8'h80);
        check(8'({temp_ext, sens_pwr}), 8'h02);
        pins.thermal_power_setting = 1'b1;
        host.idle(2);
        check(8'({temp_ext, sens_pwr}), 8'h03);
        pins.thermal_power_setting = 1'b0;
        put(8'hb6, 8'h20);
        check(8'({temp_ext, sens_pwr}), 8'h01);
        // Two back-to-back iterations per enable pattern.
        for (int i = 0; i < 4; i++) begin
            put(8'hb7, lv[i]);
            check(8'(track), 8'(lv[i][4] & lv[i][0]));
            exp_p = {lv[i][7], lv[i][6], lv[i][3], lv[i][2]} & {4{lv[i][0]}};
            loop_start = 1'b1;
            @(negedge clk_i);
            check(8'(pulses), 8'(exp_p));
            @(negedge clk_i);
            check(8'(pulses), 8'(exp_p));
            loop_start = 1'b0;
            @(negedge clk_i);
            check(8'(pulses), 8'h00);
        end
        pins.lowpower_pin = 1'b1;
        for (int k = 0; k < 4; k++) begin
            put(8'hb8, {3'h0, k[1], 3'h0, k[0]});
            check(8'({rx_pd, tx_pd}), 8'(k));
        end
        pins.lowpower_pin = 1'b0;
        host.idle(2);
        check(8'({rx_pd, tx_pd}), 8'h00);
        // Strictly above threshold selects the upper set.
        put(8'hba, 8'h80);
        rx_code = 8'h80;
        host.idle(2);
        check(8'(rcv_up), 8'h00);
        rx_code = 8'h81;
        host.idle(2);
        check(8'(rcv_up), 8'h01);
        // Pin functions, polarities and quiet masks.
        pins.tx_fault = 1'b1;
        pins.rx_signal_present = 1'b1;
        put(8'hbf, 8'h04);
        for (int i = 0; i < 3; i++) begin
            put(8'hbe, pv[i]);
            check(8'(pinv), pe[i]);
        end
        put(8'hbf, 8'h03);
        check(8'(pinv), 8'h18);
        // Forced fault holds until written back.
        pins.txfault_soft_en = 1'b1;
        put(8'hc0, 8'h01);
        check(8'({sf_tx, sf_sd}), 8'h02);
        pins.shutdown_soft_en = 1'b1;
        put(8'hbe, 8'h00);
        check(8'({sf_tx, sf_sd}), 8'h03);
        put(8'hc0, 8'h00);
        check(8'({sf_tx, sf_sd}), 8'h00);
        complete_run();
    end
endmodule : tb_top
